// ---- rtl/srcrg_pkg.sv ----
// constants of the reset and output-gating block, plus its pin synchroniser
package srcrg_pkg;
   // -------------------------------------------------------------
   // clock and time figures
   // -------------------------------------------------------------
   localparam int CLK_HZ = 250_000_000;
   localparam int CYC_PER_MS = CLK_HZ / 1000;
   localparam int T_SHORT_RESET_MS = 10;
   localparam int T_VALID_SHORT_MS = 100;
   localparam int T_VALID_LONG_MS = 200;
   localparam int T_LOCK_MARGIN_MS = 20; // budget left for lock, so the limits stay strict
   localparam int T_CLK_LOSS_MS = 1;
   localparam int SHORT_RESET_CYC = T_SHORT_RESET_MS * CYC_PER_MS;
   localparam int SETTLE_SHORT_CYC = (T_VALID_SHORT_MS - T_LOCK_MARGIN_MS) * CYC_PER_MS;
   localparam int SETTLE_LONG_CYC = (T_VALID_LONG_MS - T_LOCK_MARGIN_MS) * CYC_PER_MS;
   localparam int CLK_LOSS_CYC = T_CLK_LOSS_MS * CYC_PER_MS;
   // -------------------------------------------------------------
   // counts and widths
   // -------------------------------------------------------------
   localparam int MUTE_STEPS = 1024;
   localparam int LOCK_PERIODS = 16;
   localparam int TOL_SHIFT = 6; // 1/64 of a period: wider than 0.01 UI jitter and 23 %/s drift
   localparam int TIMER_W = 26;
   localparam int PER_W = 18;
   localparam int GAIN_W = 11;
   localparam int LOCK_W = 5;

   typedef enum logic [2:0] {
      ST_PD = 3'h0,
      ST_LOCK = 3'h1,
      ST_SETTLE = 3'h3,
      ST_NORM = 3'h2,
      ST_OHALT = 3'h6
   } srcrg_state_e;
endpackage : srcrg_pkg

`timescale 1ns/1ps
`default_nettype none
// two-stage synchroniser with rising-edge detect for a pin
module srcrg_sync_edge (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst,
   // pin
   input wire logic i_pin,
   // synchronised view
   output logic o_level,
   output logic o_rise
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
   } srcrg_sync_s;

   srcrg_sync_s r_reg;
   srcrg_sync_s r_next;

   // shift chain; only s1 -> s2 reads the first stage
   always_comb begin
      r_next.s1 = i_pin;
      r_next.s2 = r_reg.s1;
      r_next.s3 = r_reg.s2;
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign o_level = r_reg.s2;
   assign o_rise = r_reg.s2 & ~r_reg.s3;
endmodule : srcrg_sync_edge
`default_nettype wire

// ---- rtl/srcrg_reset_gate.sv ----
// reset sequencing, lock tracking, output gating and soft-mute ramp
`timescale 1ns/1ps
`default_nettype none
module srcrg_reset_gate #(
   parameter int unsigned SHORT_RESET_CYC = srcrg_pkg::SHORT_RESET_CYC,
   parameter int unsigned SETTLE_SHORT_CYC = srcrg_pkg::SETTLE_SHORT_CYC,
   parameter int unsigned SETTLE_LONG_CYC = srcrg_pkg::SETTLE_LONG_CYC,
   parameter int unsigned CLK_LOSS_CYC = srcrg_pkg::CLK_LOSS_CYC,
   parameter int unsigned MUTE_STEPS = srcrg_pkg::MUTE_STEPS
) (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst,
   // control pins
   input wire logic i_power_down_n,
   input wire logic i_soft_mute_request,
   // frame clocks
   input wire logic i_input_frame_clock,
   input wire logic i_output_frame_clock,
   // converter core data bit, same clock domain
   input wire logic i_conv_bit,
   // outputs
   output logic o_serial_out_line,
   output logic o_filter_init,
   output logic o_data_valid,
   output logic o_locked,
   output logic [srcrg_pkg::GAIN_W-1:0] o_mute_gain
);
   localparam int TW = srcrg_pkg::TIMER_W;
   localparam int PW = srcrg_pkg::PER_W;
   localparam int GW = srcrg_pkg::GAIN_W;
   localparam int LW = srcrg_pkg::LOCK_W;

   // -------------------------------------------------------------
   // elaboration checks
   // -------------------------------------------------------------
   if (SETTLE_LONG_CYC >= (64'd1 << TW) || SHORT_RESET_CYC >= (64'd1 << TW)) begin : g_bad_timer
      $error("settle or reset count exceeds timer width");
   end
   if (CLK_LOSS_CYC >= (64'd1 << PW) || CLK_LOSS_CYC < 2) begin : g_bad_loss
      $error("clock loss count out of range");
   end
   if (MUTE_STEPS >= (1 << GW) || MUTE_STEPS < 1) begin : g_bad_mute
      $error("mute steps out of range");
   end

   // -------------------------------------------------------------
   // pin synchronisers
   // -------------------------------------------------------------
   logic pdn_s;
   logic mute_s;
   logic ife_rise;
   logic ofe_rise;

   srcrg_sync_edge u_sync_pdn (
      .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_pin(i_power_down_n), .o_level(pdn_s), .o_rise()
   );
   srcrg_sync_edge u_sync_mute (
      .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_pin(i_soft_mute_request), .o_level(mute_s), .o_rise()
   );
   srcrg_sync_edge u_sync_ifc (
      .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_pin(i_input_frame_clock), .o_level(), .o_rise(ife_rise)
   );
   srcrg_sync_edge u_sync_ofc (
      .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_pin(i_output_frame_clock), .o_level(), .o_rise(ofe_rise)
   );

   // -------------------------------------------------------------
   // state
   // -------------------------------------------------------------
   typedef struct packed {
      srcrg_pkg::srcrg_state_e st;
      logic long_rst;
      logic [TW-1:0] rst_len;
      logic [TW-1:0] timer;
      logic [PW-1:0] per_cnt;
      logic [PW-1:0] per_ref;
      logic [LW-1:0] good_cnt;
      logic [PW-1:0] ofs_cnt;
      logic [GW-1:0] gain;
      logic sout;
      logic filt_init;
   } srcrg_gate_s;

   srcrg_gate_s r_reg;
   srcrg_gate_s r_next;

   logic [PW-1:0] per_diff;
   logic per_ok;
   logic in_lost;
   logic out_lost;
   logic bad_edge;
   logic [TW-1:0] settle_last;

   // period check: a frame is good while it stays within 1/64 of the last one
   always_comb begin
      per_diff = (r_reg.per_cnt >= r_reg.per_ref) ? r_reg.per_cnt - r_reg.per_ref
                                                  : r_reg.per_ref - r_reg.per_cnt;
      per_ok = (r_reg.per_ref != '0) && (per_diff <= (r_reg.per_ref >> srcrg_pkg::TOL_SHIFT));
      in_lost = (r_reg.per_cnt == PW'(CLK_LOSS_CYC));
      out_lost = (r_reg.ofs_cnt == PW'(CLK_LOSS_CYC));
      bad_edge = ife_rise && !per_ok;
      settle_last = r_reg.long_rst ? TW'(SETTLE_LONG_CYC - 1) : TW'(SETTLE_SHORT_CYC - 1);
   end

   // next state
   always_comb begin
      r_next = r_reg;
      // frame period measurement, saturating so a stopped clock reads as lost
      if (ife_rise) begin
         r_next.per_cnt = PW'(1);
         r_next.per_ref = r_reg.per_cnt;
         r_next.good_cnt = per_ok ? ((r_reg.good_cnt == LW'(srcrg_pkg::LOCK_PERIODS)) ? r_reg.good_cnt
                                                                              : r_reg.good_cnt + LW'(1))
                                  : '0;
      end else if (!in_lost) begin
         r_next.per_cnt = r_reg.per_cnt + PW'(1);
      end else begin
         r_next.good_cnt = '0;
      end
      if (ofe_rise) begin
         r_next.ofs_cnt = '0;
      end else if (!out_lost) begin
         r_next.ofs_cnt = r_reg.ofs_cnt + PW'(1);
      end
      // sequencer
      r_next.timer = '0;
      case (r_reg.st)
         srcrg_pkg::ST_PD: begin
            if (r_reg.rst_len <= TW'(SHORT_RESET_CYC)) begin
               r_next.rst_len = r_reg.rst_len + TW'(1);
            end
            if (pdn_s) begin
               r_next.long_rst = (r_reg.rst_len > TW'(SHORT_RESET_CYC));
               r_next.st = srcrg_pkg::ST_LOCK;
            end
         end
         srcrg_pkg::ST_LOCK: begin
            // without an input clock good_cnt never fills: stay unlocked, sending zeros
            // a stale full count must not carry the block into settle once the clock is gone
            if (r_reg.good_cnt == LW'(srcrg_pkg::LOCK_PERIODS) && !in_lost) begin
               r_next.st = srcrg_pkg::ST_SETTLE;
            end
         end
         srcrg_pkg::ST_SETTLE: begin
            r_next.timer = r_reg.timer + TW'(1);
            if (in_lost || bad_edge) begin
               r_next.st = srcrg_pkg::ST_LOCK;
            end else if (r_reg.timer == settle_last) begin
               r_next.st = srcrg_pkg::ST_NORM;
            end
         end
         srcrg_pkg::ST_NORM: begin
            // slow drift and small jitter pass per_ok; a jump forces a relock
            if (in_lost || bad_edge) begin
               r_next.st = srcrg_pkg::ST_LOCK;
            end
         end
         srcrg_pkg::ST_OHALT: begin
            if (ofe_rise) begin
               r_next.long_rst = 1'b0;
               r_next.st = srcrg_pkg::ST_LOCK;
            end
         end
         default: begin
            r_next.st = srcrg_pkg::ST_PD;
         end
      endcase
      // stopped output clock resets the path from any running state
      if (out_lost && r_reg.st != srcrg_pkg::ST_PD && r_reg.st != srcrg_pkg::ST_OHALT && !ofe_rise) begin
         r_next.st = srcrg_pkg::ST_OHALT;
      end
      // power-down overrides everything
      if (!pdn_s) begin
         r_next.st = srcrg_pkg::ST_PD;
         if (r_reg.st != srcrg_pkg::ST_PD) begin
            r_next.rst_len = '0;
         end
      end
      r_next.filt_init = (r_next.st == srcrg_pkg::ST_PD) || (r_next.st == srcrg_pkg::ST_OHALT);
      r_next.sout = (r_next.st == srcrg_pkg::ST_NORM) && i_conv_bit;
      // soft mute ramp: one step per output frame
      if (ofe_rise) begin
         if (mute_s && r_reg.gain != '0) begin
            r_next.gain = r_reg.gain - GW'(1);
         end else if (!mute_s && r_reg.gain != GW'(MUTE_STEPS)) begin
            r_next.gain = r_reg.gain + GW'(1);
         end
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         r_reg <= '0;
         r_reg.st <= srcrg_pkg::ST_PD;
         r_reg.gain <= GW'(MUTE_STEPS);
         r_reg.filt_init <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end

   // outputs
   assign o_serial_out_line = r_reg.sout;
   assign o_filter_init = r_reg.filt_init;
   assign o_data_valid = (r_reg.st == srcrg_pkg::ST_NORM);
   assign o_locked = (r_reg.st == srcrg_pkg::ST_SETTLE) || (r_reg.st == srcrg_pkg::ST_NORM);
   assign o_mute_gain = r_reg.gain;

   // -------------------------------------------------------------
   // assertions
   // -------------------------------------------------------------
   property p_pd_filter;
      @(posedge i_clk_sys) disable iff (i_rst) !pdn_s |=> o_filter_init && r_reg.st == srcrg_pkg::ST_PD;
   endproperty
   a_pd_filter: assert property (p_pd_filter) else $error("filter not held in power-down");

   property p_pd_zero;
      @(posedge i_clk_sys) disable iff (i_rst) !pdn_s |=> !o_serial_out_line;
   endproperty
   a_pd_zero: assert property (p_pd_zero) else $error("output not low in power-down");

   property p_zero_invalid;
      @(posedge i_clk_sys) disable iff (i_rst) !o_data_valid |-> !o_serial_out_line;
   endproperty
   a_zero_invalid: assert property (p_zero_invalid) else $error("output moved before data valid");

   property p_settle_end;
      @(posedge i_clk_sys) disable iff (i_rst)
         r_reg.st == srcrg_pkg::ST_SETTLE && r_reg.timer == settle_last && pdn_s && !in_lost && !bad_edge
         && !out_lost |=> o_data_valid;
   endproperty
   a_settle_end: assert property (p_settle_end) else $error("settle did not end on time");

   property p_settle_bound;
      @(posedge i_clk_sys) disable iff (i_rst)
         r_reg.st == srcrg_pkg::ST_SETTLE |-> r_reg.timer <= settle_last;
   endproperty
   a_settle_bound: assert property (p_settle_bound) else $error("settle overran its limit");

   property p_out_stop;
      @(posedge i_clk_sys) disable iff (i_rst)
         pdn_s && out_lost && !ofe_rise |=> !o_data_valid ##1 (o_filter_init || $past(ofe_rise));
   endproperty
   a_out_stop: assert property (p_out_stop) else $error("no reset on output clock stop");

   property p_track;
      @(posedge i_clk_sys) disable iff (i_rst)
         o_data_valid && pdn_s && ife_rise && per_ok && !out_lost |=> o_data_valid;
   endproperty
   a_track: assert property (p_track) else $error("lost lock on an in-tolerance frame");

   property p_no_clock;
      @(posedge i_clk_sys) disable iff (i_rst)
         r_reg.st == srcrg_pkg::ST_LOCK && in_lost |=> !o_data_valid && !o_locked;
   endproperty
   a_no_clock: assert property (p_no_clock) else $error("left unlocked state without clock");

   property p_mute_down;
      @(posedge i_clk_sys) disable iff (i_rst)
         ofe_rise && mute_s && o_mute_gain != '0 |=> o_mute_gain == $past(o_mute_gain) - GW'(1);
   endproperty
   a_mute_down: assert property (p_mute_down) else $error("mute ramp step wrong");

   property p_mute_hold;
      @(posedge i_clk_sys) disable iff (i_rst) !ofe_rise |=> $stable(o_mute_gain);
   endproperty
   a_mute_hold: assert property (p_mute_hold) else $error("gain moved without a frame");
endmodule : srcrg_reset_gate
`default_nettype wire

// ---- tb/srcrg_host_model.sv ----
// host-side model: makes the input and output frame clocks toward the block
`timescale 1ns/1ps
`default_nettype none
module srcrg_host_model (
   // frame clock controls from the bench
   input wire logic i_in_run,
   input wire logic i_out_run,
   input wire logic [15:0] i_in_period_ns,
   // frame clocks toward the block
   output logic o_input_frame_clock,
   output logic o_output_frame_clock
);
   // -------------------------------------------------------------
   // input frame clock
   // -------------------------------------------------------------
   // stands low while stopped; the offset keeps it off the system clock phase
   initial begin
      o_input_frame_clock = 1'b0;
      #1.3;
      forever begin
         if (i_in_run) begin
            o_input_frame_clock = 1'b1;
            #(i_in_period_ns / 2.0);
            o_input_frame_clock = 1'b0;
            #(i_in_period_ns / 2.0);
         end else begin
            #1;
         end
      end
   end

   // -------------------------------------------------------------
   // output frame clock
   // -------------------------------------------------------------
   // fixed 48 ns frame; stopping it is how a clock change starts
   initial begin
      o_output_frame_clock = 1'b0;
      #2.7;
      forever begin
         if (i_out_run) begin
            o_output_frame_clock = 1'b1;
            #24;
            o_output_frame_clock = 1'b0;
            #24;
         end else begin
            #1;
         end
      end
   end
endmodule : srcrg_host_model
`default_nettype wire

// ---- tb/srcrg_reset_gate_test.sv ----
// self-checking bench for the reset and output-gating block
`timescale 1ns/1ps
`default_nettype none
module srcrg_reset_gate_test;
   localparam int SHORT_C = 200;
   localparam int SET_S = 300;
   localparam int SET_L = 600;
   localparam int LOSS_C = 200;
   logic i_clk_sys = 1'b0;
   logic i_rst = 1'b1;
   logic power_down_n = 1'b0;
   logic soft_mute = 1'b0;
   logic conv_bit = 1'b1;
   logic in_run = 1'b0;
   logic out_run = 1'b1;
   logic [15:0] in_period = 16'h0180;
   logic in_fclk, out_fclk, ser, finit, valid, locked;
   logic [10:0] gain;
   int err_total = 0;
   int check_count = 0;
   int cyc = 0;
   logic [15:0] pat = 16'hB3C5;

   srcrg_reset_gate #(.SHORT_RESET_CYC(SHORT_C), .SETTLE_SHORT_CYC(SET_S), .SETTLE_LONG_CYC(SET_L),
      .CLK_LOSS_CYC(LOSS_C), .MUTE_STEPS(1024)) srcrg_reset_gate_i (
      .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_power_down_n(power_down_n),
      .i_soft_mute_request(soft_mute), .i_input_frame_clock(in_fclk), .i_output_frame_clock(out_fclk),
      .i_conv_bit(conv_bit), .o_serial_out_line(ser), .o_filter_init(finit), .o_data_valid(valid),
      .o_locked(locked), .o_mute_gain(gain));

   srcrg_host_model srcrg_host_model_i (.i_in_run(in_run), .i_out_run(out_run),
      .i_in_period_ns(in_period), .o_input_frame_clock(in_fclk), .o_output_frame_clock(out_fclk));

   // 250 MHz system clock
   initial begin
      forever #2 i_clk_sys = ~i_clk_sys;
   end

   // hang guard: the whole sequence needs well under this many cycles
   always @(posedge i_clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         err_total++;
         end_sim();
      end
   end

   task automatic end_sim();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : end_sim

   task automatic tick(input int n);
      repeat (n) @(posedge i_clk_sys);
      #1;
   endtask : tick

   task automatic chk_bit(input string nm, input logic e, input logic g);
      check_count++;
      if (g !== e) begin
         err_total++;
         $display("wrong value %s expected %b seen %b", nm, e, g);
      end
   endtask : chk_bit

   task automatic chk_gain(input logic [10:0] e, input logic [10:0] g);
      check_count++;
      if (g !== e) begin
         err_total++;
         $display("wrong value mute_gain expected %0d seen %0d", e, g);
      end
   endtask : chk_gain

   task automatic chk_range(input string nm, input int lo, input int hi, input int g);
      check_count++;
      if (g < lo || g > hi) begin
         err_total++;
         $display("wrong value %s expected %0d..%0d seen %0d", nm, lo, hi, g);
      end
   endtask : chk_range

   // power-down pulse of n + 1 cycles, driven on the rising edge
   task automatic pd_pulse(input int n, input logic [15:0] per);
      @(posedge i_clk_sys);
      power_down_n <= 1'b0;
      in_period <= per;
      tick(n);
      chk_bit("filter_init", 1'b1, finit);
      chk_bit("serial_out", 1'b0, ser);
      @(posedge i_clk_sys);
      power_down_n <= 1'b1;
   endtask : pd_pulse

   // waits for valid data; serial must stay low meanwhile; settle measured from lock
   task automatic settle(input int exp);
      int n;
      int m;
      n = 0;
      m = 0;
      tick(4);
      while (valid !== 1'b1 && n < 6000) begin
         if (ser !== 1'b0) chk_bit("serial_out_before_valid", 1'b0, ser);
         if (locked === 1'b1) m++;
         tick(1);
         n++;
      end
      chk_bit("data_valid", 1'b1, valid);
      chk_range("settle_cycles", exp - 2, exp + 3, m);
   endtask : settle

   initial begin
      // -------------------------------------------------------------
      // reset and a long first power-down with no input clock
      // -------------------------------------------------------------
      tick(3);
      i_rst <= 1'b0;
      chk_gain(11'h400, gain);
      pd_pulse(300, 16'h0180);
      tick(1000);
      chk_bit("locked", 1'b0, locked);
      chk_bit("data_valid", 1'b0, valid);
      chk_bit("serial_out", 1'b0, ser);
      chk_bit("filter_init", 1'b0, finit);
      in_run <= 1'b1;
      settle(SET_L);
      // -------------------------------------------------------------
      // data passes one cycle late once valid
      // -------------------------------------------------------------
      for (int i = 0; i < 16; i++) begin
         @(posedge i_clk_sys);
         conv_bit <= pat[i];
         #1;
         if (i > 0) chk_bit("serial_out", pat[i-1], ser);
      end
      // -------------------------------------------------------------
      // clock change: input zeroed first, reset at the short boundary
      // -------------------------------------------------------------
      conv_bit <= 1'b0;
      pd_pulse(SHORT_C, 16'h0150);
      conv_bit <= 1'b1;
      settle(SET_S);
      // -------------------------------------------------------------
      // one-cycle jitter on the input frame clock, alternating between two periods
      // -------------------------------------------------------------
      for (int i = 0; i < 40; i++) begin
         in_period <= (i % 2) ? 16'h0154 : 16'h0150;
         tick(97);
         chk_bit("data_valid", 1'b1, valid);
      end
      in_period <= 16'h0150;
      // -------------------------------------------------------------
      // output clock stops, then restarts
      // -------------------------------------------------------------
      out_run <= 1'b0;
      tick(LOSS_C + 60);
      chk_bit("filter_init", 1'b1, finit);
      chk_bit("serial_out", 1'b0, ser);
      chk_bit("data_valid", 1'b0, valid);
      out_run <= 1'b1;
      settle(SET_S);
      // -------------------------------------------------------------
      // soft mute ramp down and back up
      // -------------------------------------------------------------
      soft_mute <= 1'b1;
      tick(512 * 12);
      chk_range("mute_gain_half", 509, 515, gain);
      tick(520 * 12);
      chk_gain(11'h000, gain);
      soft_mute <= 1'b0;
      tick(1030 * 12);
      chk_gain(11'h400, gain);
      end_sim();
   end
endmodule : srcrg_reset_gate_test
`default_nettype wire
